// ==== inc/spsc_pkg.sv ====
package spsc_pkg;

  localparam int unsigned NUM_PORTS = 4;

  // byte addresses
  localparam logic [15:0] PORT0_CONTROL_OFS = 16'h115c;
  localparam logic [15:0] PORT1_CONTROL_OFS = 16'h117c;
  localparam logic [15:0] PORT2_CONTROL_OFS = 16'h119c;
  localparam logic [15:0] PORT3_CONTROL_OFS = 16'h11bc;
  localparam logic [15:0] PORT_STRIDE = 16'h0020;
  // error and status, one per port
  localparam logic [15:0] PORT0_ERR_STAT_OFS = 16'h1158;
  // mode register
  localparam logic [15:0] MODE_CFG_OFS = 16'h1000;

  // error and status bit positions
  localparam int unsigned ES_MAINT_PEND_BIT = 4;
  localparam int unsigned ES_RSVD_BIT = 3;
  localparam int unsigned ES_FAULT_BIT = 2;
  localparam int unsigned ES_OK_BIT = 1;
  localparam int unsigned ES_UNINIT_BIT = 0;

  // control field positions
  localparam int unsigned CTL_HW_WIDTH_LSB = 30;
  localparam int unsigned CTL_TRAINED_LSB = 27;

  localparam logic [1:0] HW_WIDTH_1LANE = 2'h0;
  localparam logic [1:0] HW_WIDTH_4LANE = 2'h1;
  localparam logic [2:0] TRAINED_LANE0 = 3'h0;
  localparam logic [2:0] TRAINED_LANE2 = 3'h1;
  localparam logic [2:0] TRAINED_4LANE = 3'h2;

  localparam logic [1:0] TOPO_SINGLE = 2'h0;
  localparam logic [1:0] TOPO_MULTI = 2'h1;
  localparam int unsigned MODE_SINGLE_LANE_BIT = 2;
  localparam logic [31:0] MODE_CFG_RESET = 32'h0000_0000;

  // per-port status from link logic
  typedef struct packed {
    logic maint_notify_req;
    logic unrecov_err;
    logic in_init;
    logic out_init;
    logic ctl_sym_ok;
    logic [2:0] trained_cfg;
  } spsc_link_stat_t;

endpackage

// ==== rtl/spsc_port_stat.sv ====
`timescale 1ns/1ps
module spsc_port_stat
  import spsc_pkg::*;
#(
  parameter bit MAINT_CAPABLE = 1'b1
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire spsc_link_stat_t stat,
  input wire logic clr_we,
  input wire logic [31:0] clr_data,
  output logic [31:0] err_stat
);

  logic pend_q, pend_d;
  logic fault_q, fault_d;
  logic ok_q, ok_d;
  logic uninit_q, uninit_d;

  always_comb
  begin
    pend_d = pend_q;
    fault_d = fault_q;
    if (clr_we && clr_data[ES_MAINT_PEND_BIT])
      pend_d = 1'b0;
    if (clr_we && clr_data[ES_FAULT_BIT])
      fault_d = 1'b0;
    // set wins over clear
    if (stat.maint_notify_req && MAINT_CAPABLE)
      pend_d = 1'b1;
    if (stat.unrecov_err)
      fault_d = 1'b1;
    ok_d = stat.in_init && stat.out_init && stat.ctl_sym_ok;
    uninit_d = !(stat.in_init && stat.out_init) && !ok_d;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pend_q <= 1'b0;
      fault_q <= 1'b0;
      ok_q <= 1'b0;
      uninit_q <= 1'b1;
    end
    else
    begin
      pend_q <= pend_d;
      fault_q <= fault_d;
      ok_q <= ok_d;
      uninit_q <= uninit_d;
    end
  end

  always_comb
  begin
    err_stat = 32'h0000_0000;
    err_stat[ES_MAINT_PEND_BIT] = pend_q;
    err_stat[ES_RSVD_BIT] = 1'b0;
    err_stat[ES_FAULT_BIT] = fault_q;
    err_stat[ES_OK_BIT] = ok_q;
    err_stat[ES_UNINIT_BIT] = uninit_q;
  end

endmodule // spsc_port_stat

// ==== rtl/spsc_regs.sv ====
`timescale 1ns/1ps
module spsc_regs
  import spsc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire spsc_link_stat_t [NUM_PORTS-1:0] link_stat,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [NUM_PORTS-1:0] port_active,
  output logic multi_port_mode
);

  //****************************************
  // mode configuration
  //****************************************
  logic [31:0] mode_q, mode_d;
  logic [1:0] topo;
  logic single_lane;
  logic multi_mode;
  logic wr_acc;
  logic [NUM_PORTS-1:0] hit_ctl;
  logic [NUM_PORTS-1:0] hit_es;
  logic hit_mode;
  logic [31:0] es_word [NUM_PORTS];
  logic [31:0] ctl_word [NUM_PORTS];
  logic [2:0] trained [NUM_PORTS];
  logic [NUM_PORTS-1:0] active_d;

  // a write lands only at the edge that completes the access
  assign wr_acc = psel && penable && pready && pwrite;
  assign hit_mode = (paddr == MODE_CFG_OFS);
  assign topo = mode_q[1:0];
  assign single_lane = mode_q[MODE_SINGLE_LANE_BIT];
  assign multi_mode = single_lane && (topo == TOPO_MULTI);

  always_comb
  begin
    mode_d = mode_q;
    if (wr_acc && hit_mode)
    begin
      mode_d = 32'h0000_0000;
      mode_d[1:0] = pwdata[1:0];
      mode_d[MODE_SINGLE_LANE_BIT] = pwdata[MODE_SINGLE_LANE_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mode_q <= MODE_CFG_RESET;
    else
      mode_q <= mode_d;
  end

  //****************************************
  // per-port status and control
  //****************************************
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PORTS; gi++)
    begin : g_port
      assign hit_ctl[gi] = (paddr == 16'(PORT0_CONTROL_OFS + PORT_STRIDE * gi));
      assign hit_es[gi] = (paddr == 16'(PORT0_ERR_STAT_OFS + PORT_STRIDE * gi));

      spsc_port_stat u_stat (
        .pclk(pclk),
        .presetn(presetn),
        .stat(link_stat[gi]),
        .clr_we(wr_acc && hit_es[gi]),
        .clr_data(pwdata),
        .err_stat(es_word[gi])
      );

      always_comb
      begin
        trained[gi] = TRAINED_LANE0;
        if (gi == 0 && !single_lane && topo == TOPO_SINGLE)
        begin
          // single-port: lane 0, lane 2, or four lanes
          if (link_stat[gi].trained_cfg == TRAINED_LANE2)
            trained[gi] = TRAINED_LANE2;
          else if (link_stat[gi].trained_cfg == TRAINED_4LANE)
            trained[gi] = TRAINED_4LANE;
        end
        ctl_word[gi] = 32'h0000_0000;
        ctl_word[gi][CTL_HW_WIDTH_LSB +: 2] = (gi == 0 && !single_lane) ? HW_WIDTH_4LANE
                                                                       : HW_WIDTH_1LANE;
        ctl_word[gi][CTL_TRAINED_LSB +: 3] = trained[gi];
      end
    end
  endgenerate

  // which ports may run in the chosen topology
  always_comb
  begin
    active_d = '0;
    if (multi_mode)
      active_d = 4'h3;
    else if (!single_lane && topo == TOPO_SINGLE)
      active_d = 4'h1;
  end

  //****************************************
  // apb read path
  //****************************************
  logic [31:0] rdata_d;
  logic err_d;

  always_comb
  begin
    rdata_d = 32'h0000_0000;
    err_d = 1'b0;
    if (hit_mode)
      rdata_d = mode_q;
    else if (|hit_ctl)
    begin
      for (int i = 0; i < NUM_PORTS; i++)
        if (hit_ctl[i])
          rdata_d = ctl_word[i];
    end
    else if (|hit_es)
    begin
      for (int i = 0; i < NUM_PORTS; i++)
        if (hit_es[i])
          rdata_d = es_word[i];
    end
    else
      err_d = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      port_active <= '0;
      multi_port_mode <= 1'b0;
    end
    else
    begin
      // no wait state, answer in first access cycle
      pready <= psel && !penable;
      pslverr <= psel && !penable && err_d;
      prdata <= (psel && !penable && !pwrite) ? rdata_d : 32'h0000_0000;
      port_active <= active_d;
      multi_port_mode <= multi_mode;
    end
  end

endmodule // spsc_regs

// ==== dv/spsc_link_partner.sv ====
`timescale 1ns/1ps
module spsc_link_partner
  import spsc_pkg::*;
(
  input wire logic pclk,
  input wire logic [3:0] up,
  input wire logic [3:0] flt,
  input wire logic [3:0] ntf,
  input wire logic [2:0] trn,
  output spsc_link_stat_t [NUM_PORTS-1:0] link_stat
);
  // link up means both sides trained and clean symbols
  always_ff @(posedge pclk)
    for (int i = 0; i < 4; i++)
      link_stat[i] <= {ntf[i], flt[i], up[i], up[i], up[i], trn};
endmodule // spsc_link_partner

// ==== dv/spsc_regs_asserts.sv ====
`timescale 1ns/1ps
module spsc_regs_asserts
  import spsc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire spsc_link_stat_t [NUM_PORTS-1:0] link_stat,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [NUM_PORTS-1:0] port_active,
  input wire logic multi_port_mode
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  spsc_link_stat_t [1:0][3:0] h_q;
  spsc_link_stat_t o;
  logic es, ct;
  always_ff @(posedge pclk) h_q <= {h_q[0], link_stat};
  assign o = h_q[1][paddr[6:5] + 2'h2];
  assign es = pready && !pwrite && !pslverr && paddr[4:0] == 5'h18;
  assign ct = pready && !pwrite && !pslverr && paddr[4:0] == 5'h1c;
  sequence s_setup; psel && !penable; endsequence
  property p_rdy; s_setup |=> pready && penable; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready");
  property p_multi; multi_port_mode |-> port_active == 4'h3; endproperty
  a_multi: assert property (p_multi) else $error("active ports");
  property p_rsvd; es |-> !prdata[3]; endproperty
  a_rsvd: assert property (p_rsvd) else $error("bit 3 set");
  property p_excl; es |-> !(prdata[1] && prdata[0]); endproperty
  a_excl: assert property (p_excl) else $error("ok and uninit");
  property p_ok; es |-> prdata[1] == (o.in_init && o.out_init && o.ctl_sym_ok); endproperty
  a_ok: assert property (p_ok) else $error("ok bit");
  property p_flt; es && !prdata[2] |-> !o.unrecov_err; endproperty
  a_flt: assert property (p_flt) else $error("fault lost");
  property p_pend; es && !prdata[4] |-> !o.maint_notify_req; endproperty
  a_pend: assert property (p_pend) else $error("pending lost");
  property p_wid; ct && paddr[6:5] != 2'h2 |-> prdata[31:30] == 2'h0; endproperty
  a_wid: assert property (p_wid) else $error("width");
endmodule // spsc_regs_asserts
bind spsc_regs spsc_regs_asserts u_chk (.*);

// ==== dv/tb_spsc_regs.sv ====
`timescale 1ns/1ps
module tb_spsc_regs
  import spsc_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, multi_port_mode, er;
  logic [15:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd, wv, lf = 32'hd38f_cd6f;
  logic [3:0] port_active, up = '0, flt = '0, ntf = '0;
  logic [2:0] trn = '0;
  spsc_link_stat_t [NUM_PORTS-1:0] link_stat;
  int n_mismatch = 0, tests_run = 0, pend[4], fl[4];
  spsc_link_partner u_lp (.pclk, .up, .flt, .ntf, .trn, .link_stat);
  spsc_regs dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .link_stat,
    .prdata, .pready, .pslverr, .port_active, .multi_port_mode);
  initial forever #5 pclk = ~pclk;
  function automatic logic [31:0] nxt(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [15:0] ad(logic [15:0] b, int p);
    return b + PORT_STRIDE * 16'(p);
  endfunction
  task automatic chk(logic [31:0] g, logic [31:0] e);
    tests_run++;
    n_mismatch += int'(g !== e);
    if (g !== e)
      $display("MISMATCH %0t %h %h", $time, g, e);
  endtask
  task automatic complete_run;
    if (n_mismatch == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic apb(bit w, logic [15:0] a, logic [31:0] d);
    int i = 0;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do
      @(posedge pclk);
    while (pready !== 1'b1 && ++i < 8);
    if (pready !== 1'b1)
    begin
      n_mismatch++;
      complete_run();
    end
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rd_es(int p);
    apb(0, ad(PORT0_ERR_STAT_OFS, p), '0);
    chk(rd, 32'(pend[p] * 16 + fl[p] * 4 + (up[p] ? 2 : 1)));
  endtask
  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    for (int p = 0; p < 4; p++)
      rd_es(p);
    up <= lf[3:0];
    flt <= 4'h5;
    ntf <= 4'ha;
    @(posedge pclk);
    flt <= '0;
    ntf <= '0;
    for (int p = 0; p < 4; p++)
    begin
      pend[p] = p % 2;
      fl[p] = 1 - p % 2;
      rd_es(p);
    end
    for (int k = 0; k < 2; k++)
      for (int p = 0; p < 4; p++)
      begin
        lf = k ? 32'hffff_ffff : nxt(lf);
        apb(1, ad(PORT0_ERR_STAT_OFS, p), lf);
        pend[p] = lf[4] ? 0 : pend[p];
        fl[p] = lf[2] ? 0 : fl[p];
        rd_es(p);
      end
    for (int t = 0; t < 3; t++)
    begin
      trn <= 3'(t);
      lf = nxt(lf);
      apb(1, PORT0_CONTROL_OFS, lf);
      for (int p = 0; p < 4; p++)
      begin
        apb(0, ad(PORT0_CONTROL_OFS, p), '0);
        chk(rd, p ? '0 : {2'h1, 3'(t), 27'h0});
      end
    end
    for (int m = 0; m < 3; m++)
    begin
      lf = nxt(lf);
      wv = {lf[31:3], m == 0 ? 3'h5 : (m == 1 ? 3'h0 : 3'h1)};
      apb(1, MODE_CFG_OFS, wv);
      repeat (2) @(negedge pclk);
      chk(32'(port_active), m == 0 ? 32'h0000_0003 : 32'(m == 1));
      chk(32'(multi_port_mode), 32'(m == 0));
      apb(0, MODE_CFG_OFS, '0);
      chk(rd, {29'h0, wv[2:0]});
      apb(0, PORT0_CONTROL_OFS, '0);
      chk(rd, m == 0 ? '0 : {2'h1, (m == 1 ? trn : 3'h0), 27'h0});
    end
    apb(0, {4'h3, lf[11:2], 2'h0}, '0);
    chk({rd[31:1], er}, 32'h0000_0001);
    complete_run();
  end
endmodule // tb_spsc_regs
